/* pkg/spi_port_regs.svh */
// offsets, field positions and counts of the serial register port
`ifndef SPI_PORT_REGS_SVH
`define SPI_PORT_REGS_SVH
`define FRAME_BITS 24
`define ADDR_BITS 7
`define DATA_BITS 16
`define RW_POS 23
`define ADDR_MSB 22
`define ADDR_LSB 16
`define DATA_MSB 15
`define DATA_LSB 0
`define DATA_START_COUNT 8
`define COUNT_RESET 5'h00
`define DATA_RESET 16'h0000
`endif

/* pkg/spi_port_pkg.sv */
// types shared by the serial register port
package spi_port_pkg;
  typedef logic [6:0] addr_t;
  typedef logic [15:0] data_t;
  typedef enum logic {dir_write, dir_read} dir_t;
endpackage

/* logic/synth_spi_register_port.sv */
// serial register port of the synthesizer, device side
//
// Overview of operation
// - frame is 24 bits: r/w flag, address A6..A0, data D15..D0, msb first
// - data input is sampled on rising serial clock edges, except in the data portion of a readback
// - bits shift only while chip select low; clocks while high ignored
// - output pin held low during flag and address of a readback
// - readback bits launched after serial clock falling edge, captured later
// - data input ignored during the data portion of a readback
`timescale 1ns/1ps
`include "spi_port_regs.svh"

module synth_spi_register_port #(
  parameter int ADDR_W = `ADDR_BITS,
  parameter int DATA_W = `DATA_BITS
) (
  // system side
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic sdi,
  input wire logic chip_select_n,
  output logic multiplexed_output_pin,
  // register file side
  input wire spi_port_pkg::data_t rd_data,
  output spi_port_pkg::addr_t rd_addr,
  output spi_port_pkg::addr_t wr_addr,
  output spi_port_pkg::data_t wr_data,
  output logic wr_strobe
);
  import spi_port_pkg::*;

  initial begin
    if (ADDR_W != `ADDR_BITS || DATA_W != `DATA_BITS) begin
      $error("frame layout fixed at 7 address and 16 data bits");
    end
  end

  // ==========================================================
  // link domain, clocked by the serial clock edges and the chip select rising edge
  // chip select high also acts as the link reset, since sclk stops between frames
  logic [4:0] bit_cnt_reg;
  logic [23:0] shift_reg;
  logic dir_reg;
  addr_t lk_addr_reg;
  data_t lk_data_reg;
  logic wr_tog_reg;
  logic [4:0] bit_cnt_next;
  logic [23:0] shift_next;
  wire in_data = bit_cnt_reg >= 5'(`DATA_START_COUNT);
  wire read_data_phase = dir_reg && in_data;
  wire rd_ignore = read_data_phase;

  assign shift_next = rd_ignore ? shift_reg : {shift_reg[22:0], sdi};
  assign bit_cnt_next = (bit_cnt_reg == 5'(`FRAME_BITS)) ? bit_cnt_reg : bit_cnt_reg + 5'h01;

  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      bit_cnt_reg <= `COUNT_RESET;
      shift_reg <= 24'h00_0000;
      dir_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      if (bit_cnt_reg == 5'h00) begin
        dir_reg <= sdi;
      end
    end
  end

  // captured address drives the readback source once the address is in
  assign rd_addr = shift_reg[6:0];

  // launch readback data on the falling edge
  data_t out_sh_reg;
  logic out_reg;
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      out_sh_reg <= `DATA_RESET;
      out_reg <= 1'b0;
    end else if (read_data_phase && bit_cnt_reg == 5'(`DATA_START_COUNT)) begin
      out_reg <= rd_data[15];
      out_sh_reg <= {rd_data[14:0], 1'b0};
    end else if (read_data_phase) begin
      out_reg <= out_sh_reg[15];
      out_sh_reg <= {out_sh_reg[14:0], 1'b0};
    end else begin
      out_reg <= 1'b0;
    end
  end
  assign multiplexed_output_pin = out_reg;

  // last write frame kept apart: deselect clears the counter at the very edge that commits
  logic pend_ok_reg;
  logic [23:0] pend_word_reg;
  wire frame_ok_next = (bit_cnt_next == 5'(`FRAME_BITS)) && !dir_reg;
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ok_reg <= 1'b0;
      pend_word_reg <= 24'h00_0000;
    end else if (!chip_select_n) begin
      pend_ok_reg <= frame_ok_next;
      pend_word_reg <= shift_next;
    end
  end

  // complete write frame latched when chip select rises
  always_ff @(posedge chip_select_n or negedge rst_n) begin
    if (!rst_n) begin
      lk_addr_reg <= 7'h00;
      lk_data_reg <= `DATA_RESET;
      wr_tog_reg <= 1'b0;
    end else if (pend_ok_reg) begin
      lk_addr_reg <= pend_word_reg[`ADDR_MSB:`ADDR_LSB];
      lk_data_reg <= pend_word_reg[`DATA_MSB:`DATA_LSB];
      wr_tog_reg <= ~wr_tog_reg;
    end
  end

  // ==========================================================
  // system domain: toggle crossing, three stages
  logic [2:0] tog_sync_reg;
  wire wr_event = tog_sync_reg[2] ^ tog_sync_reg[1];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_sync_reg <= 3'h0;
      wr_addr <= 7'h00;
      wr_data <= `DATA_RESET;
      wr_strobe <= 1'b0;
    end else begin
      tog_sync_reg <= {tog_sync_reg[1:0], wr_tog_reg};
      wr_strobe <= wr_event;
      if (wr_event) begin
        wr_addr <= lk_addr_reg;
        wr_data <= lk_data_reg;
      end
    end
  end
endmodule

/* testbench/spi_port_chk.sv */
// checker on the port pins
`timescale 1ns/1ps
module spi_port_chk(input wire logic ref_clk, input wire logic rst_n, input wire logic chip_select_n,
  input wire logic multiplexed_output_pin, input wire logic wr_strobe,
  input wire logic [6:0] wr_addr, input wire logic [15:0] wr_data);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse; wr_strobe ##1 !wr_strobe; endsequence
  sequence s_selected; (!chip_select_n) [*5]; endsequence
  property p_quiet_select; s_selected |-> !wr_strobe; endproperty
  property p_data_stable; ($changed(wr_data) || $changed(wr_addr)) |-> $rose(wr_strobe); endproperty
  property p_hold_after; $rose(wr_strobe) |=> ($stable(wr_data) && $stable(wr_addr)) [*3]; endproperty
  a_quiet_select: assert property (p_quiet_select) else $error("strobe while selected");
  a_data_stable: assert property (p_data_stable) else $error("write word moved without strobe");
  a_hold_after: assert property (p_hold_after) else $error("write word not held");
  property p_idle_low; chip_select_n |-> !multiplexed_output_pin; endproperty
  property p_one_pulse; $rose(wr_strobe) |-> s_pulse; endproperty
  property p_after_cs; $rose(wr_strobe) |-> $past(chip_select_n, 2); endproperty
  a_idle_low: assert property (p_idle_low) else $error("pin high while deselected");
  a_one_pulse: assert property (p_one_pulse) else $error("strobe too long");
  a_after_cs: assert property (p_after_cs) else $error("strobe before deselect");
endmodule

/* testbench/spi_ctrl_model.sv */
// serial controller model
`timescale 1ns/1ps
module spi_ctrl_model(output logic sclk, output logic sdi, output logic chip_select_n,
  input wire logic multiplexed_output_pin);
  initial begin sclk = 0; sdi = 0; chip_select_n = 1; end
  // clock stands still between frames
  task automatic xfer(input logic [23:0] f, input int n, output logic [15:0] q);
    #17;
    chip_select_n = 0;
    for (int i = 0; i < n; i++) begin
      sdi = f[23 - i];
      #62.5 sclk = 1;
      if (i > 7) q = {q[14:0], multiplexed_output_pin};
      #62.5 sclk = 0;
    end
    #62.5 chip_select_n = 1;
    sdi = ~sdi;
  endtask
endmodule

/* testbench/synth_spi_register_port_tb.sv */
// testbench of the serial register port
`timescale 1ns/1ps
module synth_spi_register_port_tb;
  import spi_port_pkg::*;
  logic ref_clk, rst_n, sclk, sdi, chip_select_n, multiplexed_output_pin, wr_strobe;
  data_t rd_data, wr_data, q;
  addr_t rd_addr, wr_addr;
  logic [22:0] exp_q[$];
  logic [31:0] seed = 32'h0000_0056;
  int err_count, check_count, cyc;
  initial begin ref_clk = 0; forever #50 ref_clk = ~ref_clk; end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; return s ^ (s << 5);
  endfunction
  task automatic check(input string name, input logic [22:0] seen, input logic [22:0] exp);
    check_count++;
    if (seen !== exp) begin err_count++; $display("[FAIL] %s exp %h seen %h", name, exp, seen); end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  synth_spi_register_port u_dut(.ref_clk, .rst_n, .sclk, .sdi, .chip_select_n, .multiplexed_output_pin,
    .rd_data, .rd_addr, .wr_addr, .wr_data, .wr_strobe);
  spi_ctrl_model u_ctl(.sclk, .sdi, .chip_select_n, .multiplexed_output_pin);
  // hang guard, well past 12 frames
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin err_count++; summarize(); end
  end
  always @(negedge ref_clk) if (wr_strobe === 1'b1) check("write", {wr_addr, wr_data}, exp_q.size() ? exp_q.pop_front() : 'x);
  initial begin
    rst_n = 0; rd_data = '0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1;
    for (int k = 0; k < 12; k++) begin
      seed = xs(seed);
      @(posedge ref_clk) rd_data <= seed[31:16];
      if (k[1:0] == 0) exp_q.push_back(seed[22:0]);
      u_ctl.xfer({k[0], seed[22:0]}, k[1] ? 23 : 24, q);
      if (k[1:0] == 1) check("readback", q, seed[31:16]);
      repeat (6) @(posedge ref_clk);
    end
    check("pending", exp_q.size(), 0);
    summarize();
  end
endmodule
bind synth_spi_register_port spi_port_chk u_chk(.ref_clk, .rst_n, .chip_select_n, .multiplexed_output_pin, .wr_strobe,
  .wr_addr, .wr_data);
